// File: hdl/pcl_device.sv
// configuration loading device: clear, byte load with crc check, start-up
//
// Decided for this implementation: the register addresses and the plain strobed port.
`default_nettype none
// How it works
// - running crc over payload bytes only, compared
// - crc mismatch drives init low, aborts
// - host pulses program before each retry
// - start-up only after matching crc
// - done, output release, reset release, store enable
// - release float net enables assigned outputs
// - flop reset held until its start-up step
// - store enable asserted last of all
// - optional wait for shared done high
// - one byte per clock on byte lane
// - direction change while selected aborts
// - host never drives lane during reads
// - byte taken on rising edge, busy low
// - busy high holds off taking byte
// - host deselects after each byte of the stream
// - host selects one device at a time
// - program low drops done, starts clearing
// - init low while clearing, extendable externally
// - release init, sample mode pins then
module pcl_device (
    input  wire logic REF_CLK_I,
    input  wire logic ARST_N_I,
    pcl_if.device     LINK,
    input  wire logic [1:0] MODE_PINS_I,
    input  wire logic SYNC_TO_DONE_I,
    output logic      FLOAT_RELEASE_O,
    output logic      FLOP_RESET_O,
    output logic      STORE_EN_O,
    output logic      FRAME_ERR_O,
    output logic [1:0] MODE_O
);
    typedef enum logic [6:0] {
        ST_CLEAR = 7'h01, ST_LOAD = 7'h02, ST_ERROR = 7'h04, ST_DONE = 7'h08,
        ST_FLOAT = 7'h10, ST_FRST = 7'h20, ST_GWE = 7'h40
    } pcl_dev_st_t;

    // two-flop synchronisers for every pin from the host
    logic [12:0] sync1_r, sync2_r;
    wire  [12:0] pins_raw = {LINK.cfg_clk, LINK.sel_n, LINK.wr_n, LINK.config_byte_lane,
                             LINK.prog_n, LINK.init_n};
    always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            // idle pin levels, so reset shows no false select or program request
            sync1_r <= 13'h0C02;
            sync2_r <= 13'h0C02;
        end else begin
            sync1_r <= pins_raw;
            sync2_r <= sync1_r;
        end
    end
    logic [1:0] dsync_r;
    always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) dsync_r <= 2'h0;
        else dsync_r <= {dsync_r[0], LINK.done_others_n};
    end
    wire       s_clk  = sync2_r[12];
    wire       s_sel  = ~sync2_r[11];
    wire       s_wr   = ~sync2_r[10];
    wire [7:0] s_data = sync2_r[9:2];
    wire       s_prog = ~sync2_r[1];
    wire       s_init = sync2_r[0];
    wire       others_done = dsync_r[1];

    logic clk_d_r;
    always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) clk_d_r <= 1'b0;
        else clk_d_r <= s_clk;
    end
    wire clk_rise = s_clk & ~clk_d_r;

    pcl_dev_st_t st_r, st_nxt;
    logic [15:0] cnt_r, cnt_nxt;
    logic [15:0] crc_r, len_r, rx_crc_r, bytes_r;
    logic        busy_r, done_r, flt_r, frst_r, gwe_r, err_r, init_drv_r, wr_prev_r;
    logic        sel_prev_r;
    logic [1:0]  mode_r;
    logic [2:0]  busy_cnt_r;

    // bitwise crc-16 step over one byte
    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] x;
        x = c;
        for (int i = 7; i >= 0; i--) begin
            x = (x[15] ^ d[i]) ? ({x[14:0], 1'b0} ^ pcl_pkg::CRC_POLY) : {x[14:0], 1'b0};
        end
        return x;
    endfunction

    wire take      = (st_r == ST_LOAD) && clk_rise && s_sel && s_wr && !busy_r;
    wire dir_flip  = (st_r == ST_LOAD) && clk_rise && s_sel && sel_prev_r
                     && (s_wr != wr_prev_r);
    wire in_hdr    = bytes_r < 16'(pcl_pkg::HDR_BYTES);
    wire in_body   = !in_hdr && (bytes_r < len_r + 16'(pcl_pkg::HDR_BYTES));
    wire last_byte = !in_hdr && !in_body
                     && (bytes_r == len_r + 16'(pcl_pkg::HDR_BYTES + pcl_pkg::TRL_BYTES - 1));
    wire crc_ok    = ({rx_crc_r[7:0], s_data} == crc_r);
    wire clear_end = (cnt_r == 16'(pcl_pkg::CLEAR_CYC - 1)) && s_init && !s_prog;
    // at least, not equal: a wait for the shared done may run the counter past the mark
    wire step_end  = (cnt_r >= 16'(pcl_pkg::STEP_CYC - 1));

    always_comb begin
        st_nxt  = st_r;
        cnt_nxt = (cnt_r == 16'hFFFF) ? cnt_r : cnt_r + 16'h0001;
        unique case (st_r)
            ST_CLEAR: if (clear_end) begin
                st_nxt = ST_LOAD;
            end else if (s_prog || !s_init) begin
                cnt_nxt = (cnt_r < 16'(pcl_pkg::CLEAR_CYC - 1)) ? cnt_nxt : cnt_r;
            end
            ST_LOAD: if (dir_flip) begin
                st_nxt = ST_ERROR;
            end else if (take && last_byte) begin
                st_nxt  = crc_ok ? ST_DONE : ST_ERROR;
                cnt_nxt = 16'h0000;
            end
            ST_DONE: if (step_end && (!SYNC_TO_DONE_I || others_done)) begin
                st_nxt  = ST_FLOAT;
                cnt_nxt = 16'h0000;
            end
            ST_FLOAT: if (step_end) begin
                st_nxt  = ST_FRST;
                cnt_nxt = 16'h0000;
            end
            ST_FRST: if (step_end) begin
                st_nxt  = ST_GWE;
                cnt_nxt = 16'h0000;
            end
            ST_ERROR, ST_GWE: st_nxt = st_r;
            default: st_nxt = ST_CLEAR;
        endcase
        if (s_prog) begin
            st_nxt  = ST_CLEAR;
            cnt_nxt = 16'h0000;
        end
    end

    always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            st_r  <= ST_CLEAR;
            cnt_r <= 16'h0000;
        end else begin
            st_r  <= st_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // stream parsing and crc
    always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            crc_r    <= pcl_pkg::CRC_INIT;
            len_r    <= 16'h0000;
            rx_crc_r <= 16'h0000;
            bytes_r  <= 16'h0000;
        end else if (st_r != ST_LOAD) begin
            crc_r   <= pcl_pkg::CRC_INIT;
            bytes_r <= 16'h0000;
        end else if (take) begin
            bytes_r <= bytes_r + 16'h0001;
            if (in_hdr) len_r <= {len_r[7:0], s_data};
            else if (in_body) crc_r <= crc_byte(crc_r, s_data);
            else rx_crc_r <= {rx_crc_r[7:0], s_data};
        end
    end

    // busy pacing: each accepted byte holds busy for a few cycles
    always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            busy_cnt_r <= 3'h0;
            busy_r     <= 1'b0;
        end else if (take) begin
            busy_cnt_r <= 3'(pcl_pkg::BUSY_CYC);
            busy_r     <= 1'b1;
        end else if (busy_cnt_r != 3'h0) begin
            busy_cnt_r <= busy_cnt_r - 3'h1;
            busy_r     <= (busy_cnt_r != 3'h1);
        end
    end

    always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            wr_prev_r  <= 1'b0;
            sel_prev_r <= 1'b0;
        end else if (clk_rise) begin
            wr_prev_r  <= s_wr;
            sel_prev_r <= s_sel;
        end
    end

    // mode pins caught on init low-to-high
    always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) mode_r <= 2'h0;
        else if (st_r == ST_CLEAR && st_nxt == ST_LOAD) mode_r <= MODE_PINS_I;
    end

    // outputs registered from state; start-up steps are cumulative
    always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            done_r     <= 1'b0;
            flt_r      <= 1'b0;
            frst_r     <= 1'b1;
            gwe_r      <= 1'b0;
            err_r      <= 1'b0;
            init_drv_r <= 1'b1;
        end else begin
            done_r     <= st_nxt inside {ST_DONE, ST_FLOAT, ST_FRST, ST_GWE};
            flt_r      <= st_nxt inside {ST_FLOAT, ST_FRST, ST_GWE};
            frst_r     <= !(st_nxt inside {ST_FRST, ST_GWE});
            gwe_r      <= (st_nxt == ST_GWE);
            err_r      <= (st_nxt == ST_ERROR);
            // own driver lets go once the clear time is up, so an outside hold shows
            init_drv_r <= ((st_nxt == ST_CLEAR) && (cnt_nxt != 16'(pcl_pkg::CLEAR_CYC - 1)))
                          || (st_nxt == ST_ERROR);
        end
    end

    assign LINK.busy        = busy_r;
    assign LINK.done        = done_r;
    assign LINK.init_dev_o  = 1'b0;
    assign LINK.init_dev_oe = init_drv_r;
    assign FLOAT_RELEASE_O  = flt_r;
    assign FLOP_RESET_O     = frst_r;
    assign STORE_EN_O       = gwe_r;
    assign FRAME_ERR_O      = err_r;
    assign MODE_O           = mode_r;
endmodule
`default_nettype wire

// File: hdl/pcl_pkg.sv
// shared constants for the parallel configuration loader link
`default_nettype none
package pcl_pkg;
    localparam int          BYTE_W        = 8;
    localparam int          CRC_W         = 16;
    localparam logic [15:0] CRC_POLY      = 16'h1021;
    localparam logic [15:0] CRC_INIT      = 16'hFFFF;
    // stream framing: 2-byte length, payload, 2-byte crc (high byte first)
    localparam int          HDR_BYTES     = 2;
    localparam int          TRL_BYTES     = 2;
    localparam int          CLEAR_NS      = 2000;
    localparam int          CLK_MHZ       = 100;
    localparam int          CLEAR_CYC     = (CLEAR_NS * CLK_MHZ + 999) / 1000;
    localparam int          BUSY_CYC      = 4;
    localparam int          STEP_CYC      = 2;
    localparam int          LCLK_DIV      = 8;
    localparam logic [1:0]  MODE_SLAVE_PAR = 2'h2;
    localparam logic [3:0]  HOST_ADDR_CTRL = 4'h0;
    localparam logic [3:0]  HOST_ADDR_DATA = 4'h1;
    localparam logic [3:0]  HOST_ADDR_STAT = 4'h2;
    localparam int          CTRL_START_BIT = 0;
    localparam int          CTRL_PROG_BIT  = 1;
    localparam int          CTRL_WAIT_BIT  = 2;
endpackage
`default_nettype wire

// File: hdl/pcl_if.sv
// pin bundle between configuration host and loading device
`default_nettype none
interface pcl_if;
    logic       cfg_clk;
    logic       sel_n;
    logic       wr_n;
    logic [7:0] config_byte_lane;
    logic       busy;
    logic       prog_n;
    logic       init_dev_o;
    logic       init_dev_oe;
    logic       init_host_o;
    logic       init_host_oe;
    logic       done;
    logic       done_others_n;
    logic       init_n;
    assign init_n = ~((init_dev_oe & ~init_dev_o) | (init_host_oe & ~init_host_o));
    modport device (input cfg_clk, sel_n, wr_n, config_byte_lane, prog_n, init_n,
                    done_others_n, output busy, init_dev_o, init_dev_oe, done);
    modport host (output cfg_clk, sel_n, wr_n, config_byte_lane, prog_n, init_host_o,
                  init_host_oe, input busy, init_n, done);
endinterface
`default_nettype wire

// File: hdl/pcl_host.sv
// configuration host: drives program, clock and bytes to one device
`default_nettype none
module pcl_host (
    input  wire logic       REF_CLK_I,
    input  wire logic       ARST_N_I,
    pcl_if.host             LINK,
    input  wire logic [3:0] ADDR_I,
    input  wire logic [7:0] WDATA_I,
    input  wire logic       WR_I,
    input  wire logic       RD_I,
    output logic      [7:0] RDATA_O
);
    typedef enum logic [4:0] {
        H_IDLE = 5'h01, H_PROG = 5'h02, H_WINIT = 5'h04, H_SEND = 5'h08, H_END = 5'h10
    } pcl_host_st_t;

    logic [1:0] busy_s_r, init_s_r, done_s_r;
    always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            busy_s_r <= 2'h0;
            init_s_r <= 2'h0;
            done_s_r <= 2'h0;
        end else begin
            busy_s_r <= {busy_s_r[0], LINK.busy};
            init_s_r <= {init_s_r[0], LINK.init_n};
            done_s_r <= {done_s_r[0], LINK.done};
        end
    end

    pcl_host_st_t st_r;
    logic [7:0] byte_r, rdata_r;
    logic       full_r, sel_n_r, wr_n_r, prog_n_r, clk_r, last_r, init_seen_r;
    logic [2:0] div_r;
    logic [15:0] pcnt_r;

    wire wr_ctrl = WR_I && (ADDR_I == pcl_pkg::HOST_ADDR_CTRL);
    wire wr_data = WR_I && (ADDR_I == pcl_pkg::HOST_ADDR_DATA) && !full_r;
    wire tick    = (div_r == 3'(pcl_pkg::LCLK_DIV / 2 - 1));
    wire fall    = tick && clk_r;
    // synced busy at the fall shows what the device saw when it sampled the rise before
    wire sent    = fall && !sel_n_r && !busy_s_r[1];

    always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            div_r <= 3'h0;
            clk_r <= 1'b0;
        end else begin
            div_r <= tick ? 3'h0 : div_r + 3'h1;
            if (tick) clk_r <= !clk_r;
        end
    end

    always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            st_r        <= H_IDLE;
            prog_n_r    <= 1'b1;
            sel_n_r     <= 1'b1;
            wr_n_r      <= 1'b1;
            pcnt_r      <= 16'h0000;
            full_r      <= 1'b0;
            byte_r      <= 8'h00;
            last_r      <= 1'b0;
            init_seen_r <= 1'b0;
        end else begin
            if (wr_data) begin
                byte_r <= WDATA_I;
                full_r <= 1'b1;
            end
            if (wr_ctrl && WDATA_I[pcl_pkg::CTRL_WAIT_BIT]) last_r <= 1'b1;
            unique case (st_r)
                H_IDLE: if (wr_ctrl && WDATA_I[pcl_pkg::CTRL_PROG_BIT]) begin
                    st_r     <= H_PROG;
                    prog_n_r <= 1'b0;
                    pcnt_r   <= 16'h0000;
                    last_r   <= 1'b0;
                end else if (wr_ctrl && WDATA_I[pcl_pkg::CTRL_START_BIT]) begin
                    st_r <= H_SEND;
                end
                H_PROG: begin
                    pcnt_r <= pcnt_r + 16'h0001;
                    if (pcnt_r == 16'(pcl_pkg::STEP_CYC * 4)) begin
                        prog_n_r    <= 1'b1;
                        init_seen_r <= 1'b0;
                        st_r        <= H_WINIT;
                    end
                end
                H_WINIT: if (init_s_r[1]) begin
                    init_seen_r <= 1'b1;
                    st_r        <= H_IDLE;
                end
                H_SEND: if (fall && sel_n_r && full_r) begin
                    sel_n_r <= 1'b0;
                    wr_n_r  <= 1'b0;
                end else if (sent) begin
                    full_r <= 1'b0;
                    st_r   <= H_END;
                end else if (fall && sel_n_r) begin
                    st_r <= H_IDLE;
                end
                // deselect before the next rise, or the device takes the old byte again
                H_END: begin
                    sel_n_r <= 1'b1;
                    wr_n_r  <= 1'b1;
                    st_r    <= H_IDLE;
                end
                default: st_r <= H_IDLE;
            endcase
        end
    end

    wire [7:0] stat = {2'h0, last_r, init_seen_r, done_s_r[1], !init_s_r[1], full_r,
                       (st_r != H_IDLE)};
    always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) rdata_r <= 8'h00;
        else if (RD_I) rdata_r <= (ADDR_I == pcl_pkg::HOST_ADDR_STAT) ? stat : 8'h00;
    end

    assign LINK.cfg_clk          = clk_r;
    assign LINK.sel_n            = sel_n_r;
    assign LINK.wr_n             = wr_n_r;
    assign LINK.config_byte_lane = byte_r;
    assign LINK.prog_n           = prog_n_r;
    assign LINK.init_host_o      = 1'b0;
    assign LINK.init_host_oe     = 1'b0;
    assign RDATA_O               = rdata_r;
endmodule
`default_nettype wire

// File: bench/pcl_monitor.sv
// link checker: start-up order, busy pacing, clear and abort behaviour
`default_nettype none
module pcl_monitor (
    input wire logic REF_CLK_I,
    input wire logic ARST_N_I,
    input wire logic sel_n,
    input wire logic wr_n,
    input wire logic busy,
    input wire logic prog_n,
    input wire logic init_n,
    input wire logic done,
    input wire logic FLOAT_RELEASE_O,
    input wire logic FLOP_RESET_O,
    input wire logic STORE_EN_O,
    input wire logic sync_to_done,
    input wire logic FRAME_ERR_O
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (!ARST_N_I);

    a_done_then_float: assert property (
        $rose(done) && !sync_to_done |-> ##2 $rose(FLOAT_RELEASE_O))
        else $error("float release not two cycles after done");
    a_sync_holds_float: assert property (
        $rose(done) && sync_to_done |-> ##3 $rose(FLOAT_RELEASE_O))
        else $error("float release not three cycles after done in sync mode");
    a_float_then_reset: assert property ($rose(FLOAT_RELEASE_O) |-> ##2 $fell(FLOP_RESET_O))
        else $error("flop reset not released two cycles after float");
    a_reset_then_store: assert property ($fell(FLOP_RESET_O) |-> ##2 $rose(STORE_EN_O))
        else $error("store enable not two cycles after flop reset release");
    a_store_is_last: assert property (STORE_EN_O |-> done && FLOAT_RELEASE_O && !FLOP_RESET_O)
        else $error("store enable before earlier start-up steps");
    a_prog_drops_done: assert property ($fell(prog_n) |-> ##[1:4] (!done && !init_n))
        else $error("program did not drop done and start clearing");
    a_err_blocks_done: assert property (FRAME_ERR_O |-> !done && !init_n)
        else $error("frame error without init low or with done high");
    a_busy_four: assert property ($rose(busy) |-> busy [*4] ##1 !busy)
        else $error("busy pulse length wrong");
    a_dir_steady: assert property (!sel_n && !$past(sel_n) |-> $stable(wr_n))
        else $error("direction changed while selected");
    a_no_read_cycle: assert property (!(!sel_n && wr_n))
        else $error("selected with direction high while host drives the lane");
    a_no_early_done: assert property (!init_n && !$past(init_n) |-> !done)
        else $error("done high while clearing");
endmodule
`default_nettype wire

// File: bench/tb_top.sv
// self-checking bench: host and device joined over the link
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk;
    logic       arst_n;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [7:0] rdata;
    logic [1:0] mode_pins;
    logic       sync_done;
    logic       float_rel;
    logic       flop_rst;
    logic       store_en;
    logic       frame_err;
    logic [1:0] mode_seen;
    int         err_total;
    int         total_checks;
    pcl_if link ();
    // single device: the shared done line is its own done
    assign link.done_others_n = link.done;

    pcl_device u_pcl_device (.REF_CLK_I(clk), .ARST_N_I(arst_n), .LINK(link),
        .MODE_PINS_I(mode_pins), .SYNC_TO_DONE_I(sync_done), .FLOAT_RELEASE_O(float_rel),
        .FLOP_RESET_O(flop_rst), .STORE_EN_O(store_en), .FRAME_ERR_O(frame_err),
        .MODE_O(mode_seen));
    pcl_host u_pcl_host (.REF_CLK_I(clk), .ARST_N_I(arst_n), .LINK(link), .ADDR_I(addr),
        .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata));
    pcl_monitor u_pcl_monitor (.REF_CLK_I(clk), .ARST_N_I(arst_n), .sel_n(link.sel_n),
        .wr_n(link.wr_n), .busy(link.busy), .prog_n(link.prog_n), .init_n(link.init_n),
        .done(link.done), .FLOAT_RELEASE_O(float_rel), .FLOP_RESET_O(flop_rst),
        .STORE_EN_O(store_en), .sync_to_done(sync_done), .FRAME_ERR_O(frame_err));

    initial clk = 1'b0;
    always #5 clk = ~clk;

    task automatic print_verdict();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic bus_rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {b, 8'h00};
        for (int k = 0; k < 8; k++) r = r[15] ? ((r << 1) ^ pcl_pkg::CRC_POLY) : (r << 1);
        return r;
    endfunction

    // one byte through the host; waits for the pending flag to clear
    task automatic send_byte(input logic [7:0] b, input logic last);
        logic [7:0] st;
        int n;
        bus_wr(pcl_pkg::HOST_ADDR_DATA, b);
        bus_wr(pcl_pkg::HOST_ADDR_CTRL, last ? 8'h05 : 8'h01);
        n = 0;
        st = 8'h02;
        while (st[1] !== 1'b0 && n < 200) begin
            bus_rd(pcl_pkg::HOST_ADDR_STAT, st);
            n++;
        end
        if (n >= 200) chk("byte pending timeout", 16'h0000, 16'h0001);
    endtask

    // length-framed stream; bad flips bit 0 of the low crc byte
    task automatic send_stream(input logic bad);
        logic [15:0] crc;
        crc = pcl_pkg::CRC_INIT;
        send_byte(8'h00, 1'b0);
        send_byte(8'h04, 1'b0);
        for (int i = 0; i < 4; i++) begin
            send_byte(8'h3C + 8'(i * 8'h11), 1'b0);
            crc = crc_upd(crc, 8'h3C + 8'(i * 8'h11));
        end
        send_byte(crc[15:8], 1'b0);
        send_byte(crc[7:0] ^ {7'h00, bad}, 1'b1);
    endtask

    task automatic wait_sig(ref logic s, input logic v, input int lim, input string nm);
        int n;
        n = 0;
        while (s !== v && n < lim) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(nm, {15'h0, v}, {15'h0, s});
    endtask

    task automatic t_clear(input logic [1:0] m);
        @(posedge clk);
        mode_pins <= m;
        #1 chk("init low while clearing", 16'h0000, {15'h0, link.init_n});
        chk("done while clearing", 16'h0000, {15'h0, link.done});
        wait_sig(link.init_n, 1'b1, 400, "init release");
        // mode is caught once the synced release is seen, a few cycles on
        repeat (4) @(posedge clk);
        #1 chk("mode sampled", {14'h0, m}, {14'h0, mode_seen});
    endtask

    task automatic t_good();
        logic [7:0] st;
        send_stream(1'b0);
        wait_sig(link.done, 1'b1, 400, "done after good crc");
        repeat (10) @(posedge clk);
        #1 chk("start-up outputs", 16'h0101, {7'h0, float_rel, 7'h0, store_en});
        chk("flop reset released", 16'h0000, {15'h0, flop_rst});
        chk("no frame error", 16'h0000, {15'h0, frame_err});
        bus_wr(4'h9, 8'hFF);
        bus_rd(pcl_pkg::HOST_ADDR_STAT, st);
        chk("status done", 16'h0001, {15'h0, st[3]});
    endtask

    task automatic t_program(input logic [1:0] m);
        bus_wr(pcl_pkg::HOST_ADDR_CTRL, 8'h02);
        wait_sig(link.done, 1'b0, 20, "done dropped by program");
        t_clear(m);
        chk("flop reset held again", 16'h0001, {15'h0, flop_rst});
        chk("store disabled again", 16'h0000, {15'h0, store_en});
    endtask

    task automatic t_bad();
        send_stream(1'b1);
        wait_sig(frame_err, 1'b1, 400, "frame error flagged");
        repeat (20) @(posedge clk);
        #1 chk("init low on error", 16'h0000, {15'h0, link.init_n});
        chk("no done on error", 16'h0000, {15'h0, link.done});
        chk("store off on error", 16'h0000, {15'h0, store_en});
    endtask

    initial begin
        err_total = 0;
        total_checks = 0;
        arst_n = 1'b0;
        addr = 4'h0;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        mode_pins = pcl_pkg::MODE_SLAVE_PAR;
        sync_done = 1'b0;
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        t_clear(pcl_pkg::MODE_SLAVE_PAR);
        t_good();
        t_program(2'h1);
        t_bad();
        t_program(pcl_pkg::MODE_SLAVE_PAR);
        @(posedge clk);
        sync_done <= 1'b1;
        t_good();
        print_verdict();
    end

    // a whole run is under two thousand cycles; twenty thousand is far beyond it
    initial begin
        #200000;
        err_total++;
        print_verdict();
    end
endmodule
`default_nettype wire
